// ---- core/darf_pkg.sv ----
// Package: register map, reset values, ranges, timing and carrier types
// for the auxiliary run functions block.
// Assumes a 10 MHz APB clock and 16-bit parameter words.
// Notes on behaviour
// - Running, set frequency at or below sleep level for sleep delay: sleep.
// - Sleeping with run command, frequency at or above wake for delay: run.
// - Wake and sleep levels both zero disable sleep and wake entirely.
// - While sleeping the run lamp blinks with a one second period.
// - Reported power scaled by factor 0.0 to 200.0 percent, reset 100.0.
// - Dip mode 0 off, 1 decelerate then recover, 2 decelerate to stop.
// - Mode 1 recovers after bus normal longer than rebound time.
// - Dip action level 60.0-100.0 percent, pause level 80.0-100.0 percent.
// - Output swings around set frequency; zero amplitude disables swing.
// - Swing span is amplitude times set or maximum frequency by select.
// - Jump step is swing span times jump percentage, 0.0 to 50.0.
// - Swinging output is clamped between upper and lower limit frequency.
// - Rise lasts period times coefficient, fall period times the rest.
// - Length is counted pulses divided by pulses per meter.
// - Counter stops at final target and raises its reached output.
// - Intermediate target raises its output while counting continues.
`default_nettype none
package darf_pkg;
  localparam int REG_AW = 5;
  localparam int NUM_RW = 20;
  localparam int CLK_NS = 100;
  localparam int TICK_NS = 10_000_000;
  localparam int TICK_CYCLES = TICK_NS / CLK_NS;
  localparam int TICKS_PER_DECI = 10;
  localparam int PERMILLE = 1000;
  localparam int BLINK_TICKS = 50;
  localparam logic [15:0] DIP_STEP = 16'h000A;
  localparam logic [15:0] FREQ_TOP = 16'hFFFF;

  localparam logic [4:0] IDX_CTRL = 5'h00;
  localparam logic [4:0] IDX_WAKE_FREQ = 5'h01;
  localparam logic [4:0] IDX_WAKE_DELAY = 5'h02;
  localparam logic [4:0] IDX_SLEEP_FREQ = 5'h03;
  localparam logic [4:0] IDX_SLEEP_DELAY = 5'h04;
  localparam logic [4:0] IDX_POWER_CORR = 5'h05;
  localparam logic [4:0] IDX_DIP_PAUSE = 5'h06;
  localparam logic [4:0] IDX_DIP_REBOUND = 5'h07;
  localparam logic [4:0] IDX_DIP_ACTION = 5'h08;
  localparam logic [4:0] IDX_SWING_AMP = 5'h09;
  localparam logic [4:0] IDX_JUMP_PCT = 5'h0A;
  localparam logic [4:0] IDX_SWING_PERIOD = 5'h0B;
  localparam logic [4:0] IDX_RISE_COEF = 5'h0C;
  localparam logic [4:0] IDX_MAX_FREQ = 5'h0D;
  localparam logic [4:0] IDX_UPPER_FREQ = 5'h0E;
  localparam logic [4:0] IDX_LOWER_FREQ = 5'h0F;
  localparam logic [4:0] IDX_TARGET_LEN = 5'h10;
  localparam logic [4:0] IDX_PULSES_PM = 5'h11;
  localparam logic [4:0] IDX_FINAL_CNT = 5'h12;
  localparam logic [4:0] IDX_INTER_CNT = 5'h13;
  localparam logic [4:0] IDX_MEAS_LEN = 5'h14;
  localparam logic [4:0] IDX_COUNT_MON = 5'h15;
  localparam logic [4:0] IDX_POWER_MON = 5'h16;
  localparam logic [4:0] IDX_STATUS = 5'h17;
  localparam logic [4:0] IDX_OUT_FREQ = 5'h18;

  localparam int CTRL_RUN = 0;
  localparam int CTRL_SWREF = 1;
  localparam int CTRL_DIP_LO = 2;
  localparam int CTRL_LEN_CLR = 4;
  localparam int CTRL_CNT_CLR = 5;
  localparam logic [15:0] CTRL_KEEP = 16'h000F;

  typedef enum logic [1:0] {
    DARF_DIP_OFF = 2'b00,
    DARF_DIP_RECOVER = 2'b01,
    DARF_DIP_STOP = 2'b10
  } darf_dip_mode_t;

  typedef enum logic {
    DARF_S_RUN = 1'b0,
    DARF_S_SLEEP = 1'b1
  } darf_sleep_t;

  typedef enum logic [1:0] {
    DARF_D_NORMAL = 2'b00,
    DARF_D_DECEL = 2'b01,
    DARF_D_STOPPED = 2'b10
  } darf_dip_t;

  typedef struct packed {
    logic [15:0] out_freq;
    logic run_out;
    logic run_led;
    logic length_reached;
    logic final_count_reached;
    logic intermediate_count_reached;
  } darf_outs_t;

  function automatic logic [15:0] reg_reset(input logic [4:0] idx);
    case (idx)
      IDX_POWER_CORR: reg_reset = 16'h03E8;
      IDX_DIP_PAUSE: reg_reset = 16'h0384;
      IDX_DIP_REBOUND: reg_reset = 16'h0032;
      IDX_DIP_ACTION: reg_reset = 16'h0320;
      IDX_SWING_PERIOD: reg_reset = 16'h0064;
      IDX_RISE_COEF: reg_reset = 16'h01F4;
      IDX_MAX_FREQ: reg_reset = 16'h1388;
      IDX_UPPER_FREQ: reg_reset = 16'h1388;
      IDX_TARGET_LEN: reg_reset = 16'h03E8;
      IDX_PULSES_PM: reg_reset = 16'h03E8;
      IDX_FINAL_CNT: reg_reset = 16'h03E8;
      IDX_INTER_CNT: reg_reset = 16'h03E8;
      default: reg_reset = 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] reg_min(input logic [4:0] idx);
    case (idx)
      IDX_DIP_PAUSE: reg_min = 16'h0320;
      IDX_DIP_ACTION: reg_min = 16'h0258;
      IDX_PULSES_PM: reg_min = 16'h0001;
      IDX_FINAL_CNT: reg_min = 16'h0001;
      IDX_INTER_CNT: reg_min = 16'h0001;
      default: reg_min = 16'h0000;
    endcase
  endfunction

  function automatic logic [15:0] reg_max(input logic [4:0] idx);
    case (idx)
      IDX_WAKE_DELAY: reg_max = 16'hFDE8;
      IDX_SLEEP_DELAY: reg_max = 16'hFDE8;
      IDX_POWER_CORR: reg_max = 16'h07D0;
      IDX_DIP_PAUSE: reg_max = 16'h03E8;
      IDX_DIP_REBOUND: reg_max = 16'h2710;
      IDX_DIP_ACTION: reg_max = 16'h03E8;
      IDX_SWING_AMP: reg_max = 16'h03E8;
      IDX_JUMP_PCT: reg_max = 16'h01F4;
      IDX_SWING_PERIOD: reg_max = 16'h7530;
      IDX_RISE_COEF: reg_max = 16'h03E8;
      default: reg_max = 16'hFFFF;
    endcase
  endfunction
endpackage
`default_nettype wire

// ---- core/darf_hold_timer.sv ----
// Hold timer: reports once a condition has stood for a number of ticks.
// Assumes tick is a one-cycle pulse in the pclk domain.
`timescale 1ns/1ps
`default_nettype none
module darf_hold_timer
  import darf_pkg::*;
#(
  parameter int CW = 20
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic cond,
  input wire logic [CW-1:0] limit,
  output logic done
);
  logic [CW-1:0] count;

  // Count restarts whenever the condition drops, so only a steady hold counts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count <= '0;
    else if (!cond)
      count <= '0;
    else if (tick && count < limit)
      count <= count + 1'b1;
  end

  assign done = cond && (count >= limit);
endmodule
`default_nettype wire

// ---- core/darf_top.sv ----
// Auxiliary run functions: sleep/wake, power correction, dip ride-through,
// swing frequency, length measurement and dual-target counter, APB slave.
// Assumes all pin inputs are synchronous to pclk; frequencies in 0.01 Hz.
`timescale 1ns/1ps
`default_nettype none
module darf_top
  import darf_pkg::*;
#(
  parameter int TICK_DIV = TICK_CYCLES
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] set_freq,
  input wire logic [15:0] raw_power,
  input wire logic [9:0] bus_level,
  input wire logic length_pulse,
  input wire logic length_reset,
  input wire logic count_pulse,
  input wire logic count_reset,
  output darf_outs_t outs
);
  logic [15:0] cfg [NUM_RW];
  logic [31:0] tick_cnt;
  logic tick;
  logic [4:0] idx;
  logic hit;
  logic wr_en;
  logic rd_en;
  darf_sleep_t slp;
  darf_dip_t dip;
  logic sleep_done;
  logic wake_done;
  logic rebound_done;
  logic sleep_en;
  logic [6:0] blink_cnt;
  logic blink;
  logic [15:0] lim;
  logic sw_fall;
  logic [19:0] sw_t;
  logic len_q;
  logic cnt_q;
  logic [31:0] pulses;
  logic [15:0] meas_len;
  logic [15:0] count;
  logic [15:0] power_mon;
  logic len_clr;
  logic cnt_clr;
  logic [15:0] next_out;
  logic run_ok;
  logic [15:0] out_freq;
  logic run_out;
  logic run_led;
  logic len_hit;

  function automatic logic [15:0] frac(input logic [15:0] a,
                                       input logic [15:0] pm);
    logic [31:0] p;
    p = 32'(a) * 32'(pm);
    frac = 16'(p / 32'(PERMILLE));
  endfunction

  function automatic logic [19:0] deci_ticks(input logic [15:0] v);
    deci_ticks = 20'(32'(v) * 32'(TICKS_PER_DECI));
  endfunction

  // Zero-wait slave: read data loads in setup so it stands at the access edge
  assign idx = paddr[REG_AW+1:2];
  assign hit = (paddr[31:REG_AW+2] == '0) && (idx <= IDX_OUT_FREQ);
  assign wr_en = psel && penable && pwrite && hit;
  assign rd_en = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // Writes are clamped to each parameter's range; control writes are masked to bits 3:0
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < NUM_RW; i++)
        cfg[i] <= reg_reset(5'(i));
    end
    else if (wr_en && 32'(idx) < NUM_RW)
    begin
      if (idx == IDX_CTRL)
        cfg[idx] <= pwdata[15:0] & CTRL_KEEP;
      else if (pwdata[15:0] < reg_min(idx))
        cfg[idx] <= reg_min(idx);
      else if (pwdata[15:0] > reg_max(idx))
        cfg[idx] <= reg_max(idx);
      else
        cfg[idx] <= pwdata[15:0];
    end
  end

  assign len_clr = wr_en && idx == IDX_CTRL && pwdata[CTRL_LEN_CLR];
  assign cnt_clr = wr_en && idx == IDX_CTRL && pwdata[CTRL_CNT_CLR];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (rd_en && hit)
    begin
      case (idx)
        IDX_MEAS_LEN: prdata <= {16'h0000, meas_len};
        IDX_COUNT_MON: prdata <= {16'h0000, count};
        IDX_POWER_MON: prdata <= {16'h0000, power_mon};
        IDX_STATUS: prdata <= {24'h000000, outs.final_count_reached,
          outs.intermediate_count_reached, outs.length_reached,
          outs.run_led, dip, slp, outs.run_out};
        IDX_OUT_FREQ: prdata <= {16'h0000, outs.out_freq};
        default: prdata <= {16'h0000, cfg[idx]};
      endcase
    end
  end

  // Common 10 ms time base; all delays are counted in these ticks
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tick_cnt <= 32'h00000000;
    else if (tick)
      tick_cnt <= 32'h00000000;
    else
      tick_cnt <= tick_cnt + 32'h00000001;
  end
  assign tick = (tick_cnt == 32'(TICK_DIV - 1));

  assign sleep_en = (cfg[IDX_WAKE_FREQ] != '0) ||
                    (cfg[IDX_SLEEP_FREQ] != '0);

  darf_hold_timer u_sleep (
    .pclk(pclk), .presetn(presetn), .tick(tick),
    .cond(sleep_en && slp == DARF_S_RUN && cfg[IDX_CTRL][CTRL_RUN]
          && set_freq <= cfg[IDX_SLEEP_FREQ]),
    .limit(deci_ticks(cfg[IDX_SLEEP_DELAY])), .done(sleep_done)
  );

  darf_hold_timer u_wake (
    .pclk(pclk), .presetn(presetn), .tick(tick),
    .cond(slp == DARF_S_SLEEP && cfg[IDX_CTRL][CTRL_RUN]
          && set_freq >= cfg[IDX_WAKE_FREQ]),
    .limit(deci_ticks(cfg[IDX_WAKE_DELAY])), .done(wake_done)
  );

  // Losing the run command leaves sleep, so a fresh start is not held off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      slp <= DARF_S_RUN;
    else
    begin
      case (slp)
        DARF_S_RUN:
          if (sleep_done)
            slp <= DARF_S_SLEEP;
        DARF_S_SLEEP:
          if (!sleep_en || !cfg[IDX_CTRL][CTRL_RUN] || wake_done)
            slp <= DARF_S_RUN;
        default: slp <= DARF_S_RUN;
      endcase
    end
  end

  // Half-second toggle gives the one second lamp period
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      blink_cnt <= '0;
      blink <= 1'b0;
    end
    else if (slp != DARF_S_SLEEP)
    begin
      blink_cnt <= '0;
      blink <= 1'b0;
    end
    else if (tick)
    begin
      if (blink_cnt == 7'(BLINK_TICKS - 1))
      begin
        blink_cnt <= '0;
        blink <= !blink;
      end
      else
        blink_cnt <= blink_cnt + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      power_mon <= 16'h0000;
    else
      power_mon <= frac(raw_power, cfg[IDX_POWER_CORR]);
  end

  darf_hold_timer u_rebound (
    .pclk(pclk), .presetn(presetn), .tick(tick),
    .cond(dip == DARF_D_DECEL && bus_level >= cfg[IDX_DIP_PAUSE][9:0]),
    .limit(20'(cfg[IDX_DIP_REBOUND])), .done(rebound_done)
  );

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dip <= DARF_D_NORMAL;
    else
    begin
      case (dip)
        DARF_D_NORMAL:
          if (cfg[IDX_CTRL][3:2] != DARF_DIP_OFF &&
              bus_level < cfg[IDX_DIP_ACTION][9:0])
            dip <= DARF_D_DECEL;
        DARF_D_DECEL:
          if (cfg[IDX_CTRL][3:2] == DARF_DIP_OFF)
            dip <= DARF_D_NORMAL;
          else if (cfg[IDX_CTRL][3:2] == DARF_DIP_STOP)
          begin
            if (lim == '0)
              dip <= DARF_D_STOPPED;
          end
          else if (rebound_done)
            dip <= DARF_D_NORMAL;
        DARF_D_STOPPED:
          if (!cfg[IDX_CTRL][CTRL_RUN])
            dip <= DARF_D_NORMAL;
        default: dip <= DARF_D_NORMAL;
      endcase
    end
  end

  // Ride-through ceiling: falls from the live output, climbs back by steps
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      lim <= FREQ_TOP;
    else if (dip == DARF_D_NORMAL)
    begin
      if (tick)
        lim <= (lim > FREQ_TOP - DIP_STEP) ? FREQ_TOP : lim + DIP_STEP;
    end
    else if (lim > outs.out_freq)
      lim <= outs.out_freq;
    else if (tick)
      lim <= (lim < DIP_STEP) ? 16'h0000 : lim - DIP_STEP;
  end

  // Swing triangle
  logic [15:0] sw_ref;
  logic [15:0] aw;
  logic [15:0] jmp;
  logic [19:0] per_t;
  logic [19:0] rise_t;
  logic [19:0] fall_t;
  logic [19:0] dur;
  logic [17:0] span2;
  logic [17:0] ramp;
  logic signed [19:0] off;
  logic signed [19:0] raw_f;
  logic swing_on;

  assign sw_ref = cfg[IDX_CTRL][CTRL_SWREF] ? cfg[IDX_MAX_FREQ]
                                            : set_freq;
  assign aw = frac(sw_ref, cfg[IDX_SWING_AMP]);
  assign jmp = frac(aw, cfg[IDX_JUMP_PCT]);
  assign per_t = deci_ticks(cfg[IDX_SWING_PERIOD]);
  assign rise_t = 20'((64'(per_t) * 64'(cfg[IDX_RISE_COEF]))
                      / 64'(PERMILLE));
  assign fall_t = per_t - rise_t;
  assign dur = sw_fall ? fall_t : rise_t;
  assign swing_on = cfg[IDX_SWING_AMP] != '0 && per_t != '0;
  assign span2 = {1'b0, aw, 1'b0} - {2'b00, jmp};
  assign ramp = (dur == '0) ? 18'h00000 :
                18'((64'(span2) * (64'(sw_t) + 64'h1)) / 64'(dur));
  assign off = sw_fall ?
    20'(signed'({4'h0, aw - jmp})) - 20'(signed'({2'b00, ramp})) :
    20'(signed'({2'b00, ramp})) - 20'(signed'({4'h0, aw - jmp}));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sw_t <= '0;
      sw_fall <= 1'b0;
    end
    else if (!swing_on || !run_ok)
    begin
      sw_t <= '0;
      sw_fall <= 1'b0;
    end
    else if (tick)
    begin
      if (sw_t + 1'b1 >= dur)
      begin
        sw_t <= '0;
        sw_fall <= !sw_fall;
      end
      else
        sw_t <= sw_t + 1'b1;
    end
  end

  assign run_ok = cfg[IDX_CTRL][CTRL_RUN] && slp == DARF_S_RUN &&
                  dip != DARF_D_STOPPED;

  always_comb
  begin
    raw_f = 20'(signed'({4'h0, set_freq}));
    if (swing_on)
    begin
      raw_f = raw_f + off;
      if (raw_f > 20'(signed'({4'h0, cfg[IDX_UPPER_FREQ]})))
        raw_f = 20'(signed'({4'h0, cfg[IDX_UPPER_FREQ]}));
      if (raw_f < 20'(signed'({4'h0, cfg[IDX_LOWER_FREQ]})))
        raw_f = 20'(signed'({4'h0, cfg[IDX_LOWER_FREQ]}));
    end
    next_out = raw_f[15:0];
    if (16'(raw_f) > lim)
      next_out = lim;
    if (!run_ok)
      next_out = 16'h0000;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      out_freq <= 16'h0000;
      run_out <= 1'b0;
      run_led <= 1'b0;
    end
    else
    begin
      out_freq <= next_out;
      run_out <= run_ok;
      run_led <= run_ok || (slp == DARF_S_SLEEP && blink);
    end
  end

  // Length measurement; reset by pin or control bit
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      len_q <= 1'b0;
      pulses <= '0;
      meas_len <= '0;
      len_hit <= 1'b0;
    end
    else
    begin
      len_q <= length_pulse;
      if (length_reset || len_clr)
      begin
        pulses <= '0;
        meas_len <= '0;
        len_hit <= 1'b0;
      end
      else
      begin
        if (length_pulse && !len_q && pulses != '1)
          pulses <= pulses + 1'b1;
        meas_len <= 16'((64'(pulses) * 64'(TICKS_PER_DECI))
                        / 64'(cfg[IDX_PULSES_PM]));
        len_hit <= meas_len >= cfg[IDX_TARGET_LEN];
      end
    end
  end

  // Counter halts at the final target
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 1'b0;
      count <= '0;
    end
    else
    begin
      cnt_q <= count_pulse;
      if (count_reset || cnt_clr)
        count <= '0;
      else if (count_pulse && !cnt_q && count < cfg[IDX_FINAL_CNT])
        count <= count + 1'b1;
    end
  end

  assign outs = {out_freq, run_out, run_led, len_hit,
                 count >= cfg[IDX_FINAL_CNT],
                 count >= cfg[IDX_INTER_CNT]};
endmodule
`default_nettype wire

// ---- testbench/darf_aux_monitor.sv ----
// Checker for darf_top: APB answer and the counter outputs.
// Sees only the top ports; bound from the bench top file.
`timescale 1ns/1ps
`default_nettype none
module darf_aux_monitor
  import darf_pkg::*;
#(
  parameter int TICK_DIV = 10
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [15:0] set_freq,
  input wire logic [15:0] raw_power,
  input wire logic [9:0] bus_level,
  input wire logic length_pulse,
  input wire logic length_reset,
  input wire logic count_pulse,
  input wire logic count_reset,
  input wire darf_outs_t outs
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr;
  logic mapped;
  assign acc = psel && penable;
  assign wr = psel && pwrite;
  assign mapped = paddr[31:7] == 25'h0 && paddr[6:2] <= 5'h18;
  a_ready_const: assert property (pready)
    else $error("pready low");
  a_err_mapped: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped access");
  a_err_unmapped: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  a_rdata_upper: assert property (prdata[31:16] == 16'h0000)
    else $error("read data upper half set");
  a_rdata_hold: assert property (!(psel && !penable && !pwrite)
    |=> $stable(prdata)) else $error("read data moved without read");
  // Saturated counter must not drop back on its own
  a_final_hold: assert property (
    outs.final_count_reached && !count_reset && !wr
    |=> outs.final_count_reached) else $error("final flag dropped");
  a_inter_hold: assert property (
    outs.intermediate_count_reached && !count_reset && !wr
    |=> outs.intermediate_count_reached) else $error("inter flag dropped");
  a_count_clear: assert property (count_reset [*2] |->
    !outs.final_count_reached && !outs.intermediate_count_reached)
    else $error("count flags survive clear");
endmodule
`default_nettype wire

// ---- testbench/darf_pulse_source.sv ----
// Far-side pulse terminals: length and count pulse trains.
// Driven after pclk rising edges; lines idle low between pulses.
`timescale 1ns/1ps
`default_nettype none
module darf_pulse_source
(
  input wire logic pclk,
  output logic length_pulse,
  output logic count_pulse
);
  initial
  begin
    length_pulse = 1'b0;
    count_pulse = 1'b0;
  end
  // Two cycles high, two low: each edge is seen by the sampler
  task automatic send(input bit is_len, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      if (is_len)
        length_pulse <= 1'b1;
      else
        count_pulse <= 1'b1;
      repeat (2) @(posedge pclk);
      length_pulse <= 1'b0;
      count_pulse <= 1'b0;
      @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// ---- testbench/darf_top_test.sv ----
// Bench for darf_top: APB tasks, pin stimulus, expected values.
// Assumes TICK_DIV of 10, so one 10 ms tick lasts 10 pclk cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) \
  begin \
    check_count++; \
    if ((got) !== (ex)) \
    begin \
      n_mismatch++; \
      $display("MISMATCH %s exp %0h got %0h", nm, ex, got); \
    end \
  end
module darf_top_test
  import darf_pkg::*;
;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [15:0] set_freq;
  logic [15:0] raw_power;
  logic [9:0] bus_level;
  logic length_pulse;
  logic count_pulse;
  logic length_reset;
  logic count_reset;
  darf_outs_t outs;
  int n_mismatch;
  int check_count;
  int cyc;
  int half;
  logic err;
  logic [15:0] rd;
  logic [15:0] hi;
  logic [15:0] lo;
  logic [15:0] drop;
  logic [4:0] ci [5] = '{IDX_DIP_ACTION, IDX_DIP_PAUSE, IDX_JUMP_PCT,
    IDX_SWING_AMP, IDX_POWER_CORR};
  logic [15:0] cw [5] = '{16'h0064, 16'h0000, 16'h0258, 16'h07D0, 16'h0BB8};
  logic [15:0] ce [5] = '{16'h0258, 16'h0320, 16'h01F4, 16'h03E8, 16'h07D0};
  logic [15:0] pf [4] = '{16'h03E8, 16'h07D0, 16'h01F4, 16'h0000};
  logic [15:0] pe [4] = '{16'h04D2, 16'h09A4, 16'h0269, 16'h0000};
  darf_top #(.TICK_DIV(10)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .set_freq(set_freq), .raw_power(raw_power), .bus_level(bus_level),
    .length_pulse(length_pulse), .length_reset(length_reset),
    .count_pulse(count_pulse), .count_reset(count_reset), .outs(outs));
  darf_pulse_source i_src (.pclk(pclk), .length_pulse(length_pulse),
    .count_pulse(count_pulse));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      n_mismatch++;
      results();
    end
  end
  // Read data and error are taken at the edge that completes the access
  task automatic apb(input logic w, input logic [4:0] i,
    input logic [15:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {25'h0, i, 2'b00};
    pwdata <= {16'h0000, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    err = pslverr;
    rd = prdata[15:0];
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [4:0] i, input logic [15:0] ex);
    apb(1'b0, i, 16'h0000);
    `CHK("reg", ex, rd)
  endtask
  task automatic stchk(input logic [3:0] ex);
    apb(1'b0, IDX_STATUS, 16'h0000);
    `CHK("status", ex, rd[3:0])
  endtask
  task automatic watch(input int n);
    logic [15:0] p;
    hi = 16'h0000;
    lo = 16'hFFFF;
    drop = 16'h0000;
    p = outs.out_freq;
    repeat (n)
    begin
      @(negedge pclk);
      if (outs.out_freq > hi) hi = outs.out_freq;
      if (outs.out_freq < lo) lo = outs.out_freq;
      if (p > outs.out_freq && p - outs.out_freq > drop)
        drop = p - outs.out_freq;
      p = outs.out_freq;
    end
  endtask
  task automatic blink();
    logic l;
    half = 0;
    l = outs.run_led;
    while (outs.run_led === l && half < 1100)
    begin
      @(negedge pclk);
      half++;
    end
    half = 0;
    l = outs.run_led;
    while (outs.run_led === l && half < 1100)
    begin
      @(negedge pclk);
      half++;
    end
  endtask
  initial
  begin
    {psel, penable, pwrite, length_reset, count_reset} = 5'h00;
    paddr = 32'h0;
    pwdata = 32'h0;
    set_freq = 16'h01F4;
    raw_power = 16'h04D2;
    bus_level = 10'h3B6;
    presetn = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(IDX_POWER_CORR, 16'h03E8);
    rdchk(IDX_DIP_REBOUND, 16'h0032);
    rdchk(IDX_DIP_PAUSE, 16'h0384);
    rdchk(IDX_DIP_ACTION, 16'h0320);
    rdchk(IDX_SWING_PERIOD, 16'h0064);
    rdchk(IDX_RISE_COEF, 16'h01F4);
    rdchk(IDX_PULSES_PM, 16'h03E8);
    rdchk(IDX_FINAL_CNT, 16'h03E8);
    apb(1'b0, 5'h1F, 16'h0000);
    `CHK("slverr", 1'b1, err)
    for (int k = 0; k < 5; k++)
    begin
      apb(1'b1, ci[k], cw[k]);
      rdchk(ci[k], ce[k]);
    end
    for (int k = 0; k < 4; k++)
    begin
      apb(1'b1, IDX_POWER_CORR, pf[k]);
      rdchk(IDX_POWER_MON, pe[k]);
    end
    apb(1'b1, IDX_MEAS_LEN, 16'h0005);
    apb(1'b1, IDX_PULSES_PM, 16'h0014);
    apb(1'b1, IDX_TARGET_LEN, 16'h0003);
    i_src.send(1'b1, 6);
    repeat (4) @(posedge pclk);
    rdchk(IDX_MEAS_LEN, 16'h0003);
    `CHK("len_hit", 1'b1, outs.length_reached)
    length_reset <= 1'b1;
    repeat (2) @(posedge pclk);
    length_reset <= 1'b0;
    repeat (3) @(posedge pclk);
    rdchk(IDX_MEAS_LEN, 16'h0000);
    `CHK("len_hit", 1'b0, outs.length_reached)
    i_src.send(1'b1, 2);
    repeat (4) @(posedge pclk);
    rdchk(IDX_MEAS_LEN, 16'h0001);
    apb(1'b1, IDX_FINAL_CNT, 16'h0005);
    apb(1'b1, IDX_INTER_CNT, 16'h0003);
    i_src.send(1'b0, 3);
    repeat (3) @(posedge pclk);
    `CHK("inter", 1'b1, outs.intermediate_count_reached)
    `CHK("final", 1'b0, outs.final_count_reached)
    i_src.send(1'b0, 4);
    repeat (3) @(posedge pclk);
    `CHK("final", 1'b1, outs.final_count_reached)
    rdchk(IDX_COUNT_MON, 16'h0005);
    count_reset <= 1'b1;
    repeat (2) @(posedge pclk);
    count_reset <= 1'b0;
    rdchk(IDX_COUNT_MON, 16'h0000);
    apb(1'b1, IDX_WAKE_FREQ, 16'h07D0);
    apb(1'b1, IDX_SLEEP_FREQ, 16'h03E8);
    apb(1'b1, IDX_WAKE_DELAY, 16'h0001);
    apb(1'b1, IDX_SLEEP_DELAY, 16'h0001);
    apb(1'b1, IDX_CTRL, 16'h0001);
    repeat (40) @(posedge pclk);
    stchk(4'h1);
    repeat (150) @(posedge pclk);
    stchk(4'h2);
    blink();
    `CHK("blink", 1'b1, half >= 498 && half <= 502)
    set_freq <= 16'h0BB8;
    repeat (40) @(posedge pclk);
    stchk(4'h2);
    repeat (150) @(posedge pclk);
    stchk(4'h1);
    set_freq <= 16'h0000;
    apb(1'b1, IDX_WAKE_FREQ, 16'h0000);
    apb(1'b1, IDX_SLEEP_FREQ, 16'h0000);
    repeat (300) @(posedge pclk);
    stchk(4'h1);
    // Swing checks: limits clamp, then a fixed span from max frequency
    set_freq <= 16'h0BB8;
    apb(1'b1, IDX_UPPER_FREQ, 16'h0FA0);
    apb(1'b1, IDX_LOWER_FREQ, 16'h03E8);
    apb(1'b1, IDX_SWING_PERIOD, 16'h0004);
    watch(800);
    `CHK("hi", 16'h0FA0, hi)
    `CHK("lo", 16'h03E8, lo)
    apb(1'b1, IDX_UPPER_FREQ, 16'h1388);
    apb(1'b1, IDX_LOWER_FREQ, 16'h0000);
    apb(1'b1, IDX_SWING_AMP, 16'h0064);
    apb(1'b1, IDX_CTRL, 16'h0003);
    watch(800);
    `CHK("hi", 16'h0DAC, hi)
    `CHK("lo", 16'h09C4, lo)
    `CHK("jump", 1'b1, drop >= 16'h00FA)
    apb(1'b1, IDX_SWING_AMP, 16'h0000);
    apb(1'b1, IDX_CTRL, 16'h0005);
    repeat (30) @(posedge pclk);
    `CHK("freq", 16'h0BB8, outs.out_freq)
    bus_level <= 10'h1F4;
    repeat (300) @(posedge pclk);
    stchk(4'h5);
    `CHK("dec", 1'b1, outs.out_freq < 16'h0BB8)
    bus_level <= 10'h3B6;
    repeat (300) @(posedge pclk);
    stchk(4'h5);
    repeat (700) @(posedge pclk);
    stchk(4'h1);
    repeat (1200) @(posedge pclk);
    `CHK("freq", 16'h0BB8, outs.out_freq)
    apb(1'b1, IDX_CTRL, 16'h0001);
    bus_level <= 10'h1F4;
    repeat (300) @(posedge pclk);
    stchk(4'h1);
    set_freq <= 16'h01F4;
    apb(1'b1, IDX_CTRL, 16'h0009);
    repeat (700) @(posedge pclk);
    stchk(4'h8);
    bus_level <= 10'h3B6;
    repeat (600) @(posedge pclk);
    stchk(4'h8);
    results();
  end
endmodule
bind darf_top darf_aux_monitor #(.TICK_DIV(TICK_DIV)) i_mon (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .set_freq(set_freq), .raw_power(raw_power),
  .bus_level(bus_level), .length_pulse(length_pulse),
  .length_reset(length_reset), .count_pulse(count_pulse),
  .count_reset(count_reset), .outs(outs));
`default_nettype wire
